/* tb_gpio_waveform_generator.sv */
// Register-level testbench for the pad waveform generator
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_waveform_generator;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [319:0] ext_sub_len = '0;
  logic [47:0] ext_count = '0;
  logic [5:0] ext_count_wr = '0;
  logic [47:0] ext_count_rem;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic mon_clr = 1'b0;
  logic [15:0] rise7;
  logic [15:0] rise6;
  logic [31:0] t_fall7;
  logic [31:0] t_rise6;
  logic [7:0] rd;
  int failures = 0;
  int n_checks = 0;

  wg_top u_wg_top (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .ext_sub_len(ext_sub_len),
    .ext_count(ext_count),
    .ext_count_wr(ext_count_wr),
    .ext_count_rem(ext_count_rem),
    .pad_out(pad_out),
    .pad_oe(pad_oe)
  );

  wg_pad_mon u_wg_pad_mon (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clr(mon_clr),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .rise7(rise7),
    .rise6(rise6),
    .t_fall7(t_fall7),
    .t_rise6(t_rise6)
  );

  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data lands one cycle after the strobe and then holds
  task automatic rdr(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1;
    d = reg_rdata;
  endtask

  task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    rdr(a, rd);
    chk(what, {8'h00, exp}, {8'h00, rd});
  endtask

  task automatic mon_reset();
    @(posedge ref_clk);
    mon_clr <= 1'b1;
    @(posedge ref_clk);
    mon_clr <= 1'b0;
  endtask

  task automatic wait_cnt7_zero();
    int i;
    i = 0;
    rd = 8'hFF;
    while (rd !== 8'h00 && i < 60)
    begin
      rdr(wg_pkg::WG_A_CNT_P7, rd);
      i++;
    end
    if (rd !== 8'h00)
    begin
      failures++;
      $display("MISMATCH cnt7_wait expected 00 seen %h", rd);
      give_verdict();
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("MISMATCH watchdog expected finish seen hang");
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    chk("pad_oe_reset", 16'h0000, {8'h00, pad_oe});
    for (int k = 0; k < 6; k++)
    begin
      rchk("reset_value", wg_pkg::WG_A_SUB5_P7 + 16'(k), 8'h00);
    end
    rchk("unmapped", 16'h10B7, 8'h00);
    $display("test reset done");

    wr(wg_pkg::WG_A_SUB5_P7, 8'hA5);
    wr(wg_pkg::WG_A_SUB5_P6, 8'h5A);
    wr(wg_pkg::WG_A_CHAIN, 8'hFF);
    rchk("sub5_pad7", wg_pkg::WG_A_SUB5_P7, 8'hA5);
    rchk("sub5_pad6", wg_pkg::WG_A_SUB5_P6, 8'h5A);
    rchk("chain", wg_pkg::WG_A_CHAIN, 8'h7F);
    wr(wg_pkg::WG_A_SUB5_P7, 8'h00);
    wr(wg_pkg::WG_A_SUB5_P6, 8'h00);
    wr(wg_pkg::WG_A_CHAIN, 8'h00);
    $display("test readback done");

    // All subperiods one tick, ten cycles a period
    mon_reset();
    wr(wg_pkg::WG_A_CNT_P7, 8'h02);
    wr(wg_pkg::WG_A_CNT_P6, 8'h00);
    rchk("cnt7_loaded", wg_pkg::WG_A_CNT_P7, 8'h02);
    wr(wg_pkg::WG_A_CFG, 8'h08);
    #1;
    chk("pad_oe_narrow", 16'h0003, {14'h0, pad_oe[7:6]});
    wait_cnt7_zero();
    repeat (100) @(posedge ref_clk);
    chk("pad7_rises", 16'h0005, rise7);
    chk("pad6_free_run", 16'h0001, {15'h0, rise6 > 16'd8});
    $display("test narrow done");

    wr(wg_pkg::WG_A_CFG, 8'h00);
    wr(wg_pkg::WG_A_CHAIN, 8'h40);
    wr(wg_pkg::WG_A_CNT_P7, 8'h01);
    wr(wg_pkg::WG_A_CNT_P6, 8'h01);
    mon_reset();
    wr(wg_pkg::WG_A_CFG, 8'h08);
    wait_cnt7_zero();
    repeat (40) @(posedge ref_clk);
    chk("chain_started", 16'h0001, {15'h0, t_rise6 != 32'h0});
    // Allow one clock for the registered pad stage
    chk("chain_gap", 16'h0001, {15'h0, t_rise6 >= t_fall7 && t_rise6 - t_fall7 <= 1});
    $display("test chain done");

    // Wide fifth subperiod 0x0100 ticks makes one period about 520 cycles
    wr(wg_pkg::WG_A_CFG, 8'h00);
    wr(wg_pkg::WG_A_CHAIN, 8'h00);
    wr(wg_pkg::WG_A_SUB5_P7, 8'h01);
    wr(wg_pkg::WG_A_CNT_P7, 8'h01);
    wr(wg_pkg::WG_A_CNT_P6, 8'h00);
    wr(wg_pkg::WG_A_CFG, 8'h88);
    #1;
    chk("pad_oe_wide", 16'h0001, {14'h0, pad_oe[7:6]});
    rchk("wide_upper", wg_pkg::WG_A_CNT_P7, 8'h01);
    repeat (600) @(posedge ref_clk);
    rchk("wide_latched", wg_pkg::WG_A_CNT_P6, 8'h00);
    rchk("wide_upper2", wg_pkg::WG_A_CNT_P7, 8'h00);
    rchk("wide_lower2", wg_pkg::WG_A_CNT_P6, 8'hFF);
    wr(wg_pkg::WG_A_STOP, 8'hC0);
    rchk("stop_upper", wg_pkg::WG_A_CNT_P7, 8'h00);
    rchk("stop_lower", wg_pkg::WG_A_CNT_P6, 8'h00);
    $display("test wide done");

    // Pads 0-3 on both dividers, pad 2 chained behind pad 3, pads 4-5 wide
    wr(wg_pkg::WG_A_CFG, 8'h00);
    wr(wg_pkg::WG_A_CLKDIV, 8'h10);
    wr(wg_pkg::WG_A_DIVSEL, 8'h01);
    wr(wg_pkg::WG_A_CHAIN, 8'h34);
    @(posedge ref_clk);
    ext_count <= 48'h000003010303;
    ext_count_wr <= 6'h0F;
    @(posedge ref_clk);
    ext_count_wr <= 6'h00;
    #1;
    chk("ext_rem_01", 16'h0303, ext_count_rem[15:0]);
    chk("ext_rem_23", 16'h0301, ext_count_rem[31:16]);
    wr(wg_pkg::WG_A_CFG, 8'h47);
    #1;
    chk("pad_oe_mixed", 16'h001F, {8'h00, pad_oe});
    // Divider 2 at d=1 runs at half the pace of divider 1 at d=0
    repeat (33) @(posedge ref_clk);
    wr(wg_pkg::WG_A_PAUSE, 8'h01);
    #1;
    chk("div_pace", 16'h0002, ext_count_rem[15:0]);
    chk("chain_wait", 16'h0001, ext_count_rem[31:16]);
    repeat (60) @(posedge ref_clk);
    #1;
    chk("pause_hold", 16'h0002, ext_count_rem[15:0]);
    chk("chain_end", 16'h0000, ext_count_rem[31:16]);
    wr(wg_pkg::WG_A_PAUSE, 8'h00);
    repeat (60) @(posedge ref_clk);
    #1;
    chk("resume_end", 16'h0000, ext_count_rem[15:0]);
    $display("test pads done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* wg_chan.sv */
// One pad waveform channel, 8- or 16-bit lengths
`timescale 1ns/1ps
`default_nettype none
module wg_chan #(
  parameter int W = wg_pkg::WG_WW,
  parameter int NSUB = wg_pkg::WG_NSUB
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic run_en,
  input wire logic pause,
  input wire logic stop,
  input wire logic chained,
  input wire logic trig,
  input wire logic cnt_wr,
  input wire logic [NSUB*W-1:0] sub_len,
  input wire logic [W-1:0] prog_cnt,
  input wire logic [W-1:0] cnt_wdata,
  output logic pad_level,
  output logic done,
  output logic [W-1:0] rem
);
  wg_pkg::wg_state_t state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  logic [W-1:0] cnt_reg, cnt_next, rem_reg, rem_next, cur_len;
  logic adv, last_tick, last_sub;

  always_comb
  begin
    cur_len = sub_len[int'(idx_reg)*W +: W];
    // Zero length still lasts one tick, so a period never collapses
    last_tick = ({1'b0, cnt_reg} + 1'b1) >= {1'b0, cur_len};
    last_sub = idx_reg == 3'(NSUB - 1);
    adv = state_reg == wg_pkg::WG_RUN && tick && !pause && run_en && !stop;
    done = adv && last_tick && last_sub && prog_cnt != '0 && rem_reg <= 1;
    state_next = state_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    rem_next = rem_reg;
    if (stop || !run_en)
    begin
      state_next = wg_pkg::WG_IDLE;
      idx_next = '0;
      cnt_next = '0;
      rem_next = stop ? '0 : rem_reg;
    end
    else
    begin
      unique case (state_reg)
        wg_pkg::WG_IDLE:
        begin
          if ((!chained || trig) && !pause)
          begin
            state_next = wg_pkg::WG_RUN;
            idx_next = '0;
            cnt_next = '0;
            rem_next = prog_cnt;
          end
        end
        wg_pkg::WG_RUN:
        begin
          if (adv && !last_tick)
            cnt_next = cnt_reg + 1'b1;
          else if (adv)
          begin
            cnt_next = '0;
            idx_next = last_sub ? '0 : idx_reg + 1'b1;
            if (done)
            begin
              rem_next = '0;
              state_next = wg_pkg::WG_FIN;
            end
            else if (last_sub && prog_cnt != '0)
              rem_next = rem_reg - 1'b1;
          end
        end
        wg_pkg::WG_FIN: ;
        default: state_next = wg_pkg::WG_IDLE;
      endcase
    end
    if (cnt_wr)
    begin
      rem_next = cnt_wdata;
      if (!stop && run_en)
        state_next = wg_pkg::WG_IDLE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_reg <= wg_pkg::WG_IDLE;
      idx_reg <= '0;
      cnt_reg <= '0;
      rem_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      rem_reg <= rem_next;
    end
  end

  assign pad_level = state_reg == wg_pkg::WG_RUN && !idx_reg[0];
  assign rem = rem_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_chain_go;
    chained && trig && state_reg == wg_pkg::WG_IDLE && run_en && !stop && !pause && !cnt_wr;
  endsequence
  property p_chain_start;
    s_chain_go |=> state_reg == wg_pkg::WG_RUN && rem_reg == $past(prog_cnt);
  endproperty
  a_chain_start: assert property (p_chain_start) else $error("chained start missed");
  property p_finite_end;
    done && !cnt_wr |=> state_reg == wg_pkg::WG_FIN && rem_reg == '0;
  endproperty
  a_finite_end: assert property (p_finite_end) else $error("finite end wrong");
  property p_endless;
    adv && last_tick && last_sub && prog_cnt == '0 && !cnt_wr
      |=> state_reg == wg_pkg::WG_RUN && $stable(rem_reg);
  endproperty
  a_endless: assert property (p_endless) else $error("endless waveform ended");
  property p_pause_hold;
    pause && state_reg == wg_pkg::WG_RUN && run_en && !stop && !cnt_wr
      |=> $stable(cnt_reg) && $stable(idx_reg) && state_reg == wg_pkg::WG_RUN;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("paused channel moved");
  property p_stop_clear;
    stop && !cnt_wr |=> state_reg == wg_pkg::WG_IDLE && cnt_reg == '0 && idx_reg == '0
      && rem_reg == '0;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear");
endmodule
`default_nettype wire

/* wg_clkdiv.sv */
// Power-of-two tick divider
`timescale 1ns/1ps
`default_nettype none
module wg_clkdiv #(
  parameter int DW = wg_pkg::WG_DW,
  parameter int CW = wg_pkg::WG_CW
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [DW-1:0] div,
  output logic tick
);
  logic [CW-1:0] cnt_reg, cnt_next, mask;
  logic [CW-1:0] gap_reg, gap_next;
  logic [DW-1:0] div_q_reg;
  logic stab_reg, stab_next;

  always_comb
  begin
    mask = {CW{1'b1}} >> (DW'(CW - 1) - div);
    cnt_next = cnt_reg + 1'b1;
    tick = (cnt_reg & mask) == mask;
    gap_next = tick ? '0 : gap_reg + 1'b1;
    stab_next = tick ? 1'b1 : (stab_reg && div == div_q_reg);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cnt_reg <= '0;
      gap_reg <= '0;
      div_q_reg <= '0;
      stab_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      gap_reg <= gap_next;
      div_q_reg <= div;
      stab_reg <= stab_next;
    end
  end

  // Period checked only when the divisor held still
  property p_div_period;
    @(posedge ref_clk) disable iff (!rstn)
    tick && stab_reg && div == div_q_reg |-> gap_reg == mask;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period wrong");
endmodule
`default_nettype wire

/* wg_pad_mon.sv */
// Pad-side observer standing in for strobe and shutter loads
`timescale 1ns/1ps
`default_nettype none
module wg_pad_mon (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  output logic [15:0] rise7,
  output logic [15:0] rise6,
  output logic [31:0] t_fall7,
  output logic [31:0] t_rise6
);
  logic [7:0] prev;
  logic [31:0] cyc;
  // Loads only see rising edges while the generator drives the pad; pad7 falls are timed whether driven or not
  always_ff @(posedge ref_clk)
  begin
    prev <= pad_out;
    cyc <= cyc + 32'h1;
    if (!rstn || clr)
    begin
      prev <= 8'h00;
      rise7 <= 16'h0000;
      rise6 <= 16'h0000;
      t_fall7 <= 32'h0;
      t_rise6 <= 32'h0;
      if (!rstn)
      begin
        cyc <= 32'h1;
      end
    end
    else
    begin
      if (pad_out[7] && !prev[7] && pad_oe[7])
      begin
        rise7 <= rise7 + 16'h1;
      end
      if (pad_out[6] && !prev[6] && pad_oe[6])
      begin
        rise6 <= rise6 + 16'h1;
        if (t_rise6 == 32'h0)
        begin
          t_rise6 <= cyc;
        end
      end
      if (!pad_out[7] && prev[7])
      begin
        t_fall7 <= cyc;
      end
    end
  end
endmodule
`default_nettype wire

/* wg_pkg.sv */
// Shared constants and types for the pad waveform generator
package wg_pkg;
  localparam int WG_NPAD = 8;
  localparam int WG_NSUB = 5;
  localparam int WG_BW = 8;
  localparam int WG_WW = 16;
  localparam int WG_DW = 4;
  localparam int WG_CW = 16;
  localparam int WG_WIDE_LSB = 4;
  localparam int WG_SUB5_P6_IDX = 34;
  localparam int WG_SUB5_P7_IDX = 39;
  localparam logic [15:0] WG_A_SUB5_P7 = 16'h10AC;
  localparam logic [15:0] WG_A_SUB5_P6 = 16'h10AD;
  localparam logic [15:0] WG_A_CNT_P7 = 16'h10AE;
  localparam logic [15:0] WG_A_CNT_P6 = 16'h10AF;
  localparam logic [15:0] WG_A_CFG = 16'h10B0;
  localparam logic [15:0] WG_A_CHAIN = 16'h10B1;
  localparam logic [15:0] WG_A_CLKDIV = 16'h10B2;
  localparam logic [15:0] WG_A_DIVSEL = 16'h10B3;
  localparam logic [15:0] WG_A_STOP = 16'h10B5;
  localparam logic [15:0] WG_A_PAUSE = 16'h10B6;
  localparam logic [7:0] WG_RST8 = 8'h00;
  localparam logic [6:0] WG_RST7 = 7'h00;
  typedef enum logic [1:0] {
    WG_IDLE = 2'b00,
    WG_RUN = 2'b01,
    WG_FIN = 2'b10
  } wg_state_t;
endpackage

/* wg_top.sv */
// Waveform generator top: registers, pairing, chaining, pads
// Notes on behaviour
// - Pad7 sub5 byte, or pad6 upper byte.
// - Pad6 sub5 byte, or its lower byte.
// - Nonzero duration limits periods; zero runs forever.
// - Duration reads return periods still left.
// - Low config bit enables a pad pair.
// - High config bit clear: independent 8-bit pads.
// - High config bit set: one 16-bit pad.
// - Chained start coincides with previous end.
// - Even chain bit: b after b+1/b+2.
// - Odd chain bit: 8-bit only link.
// - Chain bit 6: pad6 after pad7, 8-bit.
// - Dividers divide by two to d+1.
// - Pause bit holds a pad's waveform.
// - Stop bit halts and clears pad counters.
`timescale 1ns/1ps
`default_nettype none
module wg_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [319:0] ext_sub_len,
  input wire logic [47:0] ext_count,
  input wire logic [5:0] ext_count_wr,
  output logic [47:0] ext_count_rem,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe
);
  localparam int NP = wg_pkg::WG_NPAD;
  localparam int NS = wg_pkg::WG_NSUB;
  localparam int BW = wg_pkg::WG_BW;
  localparam int WW = wg_pkg::WG_WW;

  logic [7:0] sub5_p7_reg, sub5_p7_next;
  logic [7:0] sub5_p6_reg, sub5_p6_next;
  logic [7:0] cnt_p7_reg, cnt_p7_next;
  logic [7:0] cnt_p6_reg, cnt_p6_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [6:0] chain_reg, chain_next;
  logic [7:0] clkdiv_reg, clkdiv_next;
  logic [7:0] divsel_reg, divsel_next;
  logic [7:0] stop_reg, stop_next;
  logic [7:0] pause_reg, pause_next;
  logic [7:0] cap_lo_reg, cap_lo_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] pad_reg, pad_next;
  logic [3:0] wide;
  logic [319:0] sub_all;
  logic [63:0] prog_all, prog_nx;
  logic [7:0] wr_all;
  logic wr_p7, wr_p6;
  wire [1:0] tick;
  wire [7:0] run_en;
  wire [7:0] done;
  wire [7:0] lvl;
  wire [7:0] rem_byte [NP];
  wire [15:0] chan_rem [NP];

  assign wide = cfg_reg[7:wg_pkg::WG_WIDE_LSB];
  assign wr_p7 = reg_wr && reg_addr == wg_pkg::WG_A_CNT_P7;
  assign wr_p6 = reg_wr && reg_addr == wg_pkg::WG_A_CNT_P6;

  always_comb
  begin
    sub_all = ext_sub_len;
    sub_all[wg_pkg::WG_SUB5_P6_IDX*BW +: BW] = sub5_p6_reg;
    sub_all[wg_pkg::WG_SUB5_P7_IDX*BW +: BW] = sub5_p7_reg;
    prog_all = {cnt_p7_reg, cnt_p6_reg, ext_count};
    prog_nx = {cnt_p7_next, cnt_p6_next, ext_count};
    wr_all = {wr_p7, wr_p6, ext_count_wr};
    for (int i = 0; i < NP - 2; i++)
      ext_count_rem[i*BW +: BW] = rem_byte[i];
  end

  always_comb
  begin
    sub5_p7_next = sub5_p7_reg;
    sub5_p6_next = sub5_p6_reg;
    cnt_p7_next = cnt_p7_reg;
    cnt_p6_next = cnt_p6_reg;
    cfg_next = cfg_reg;
    chain_next = chain_reg;
    clkdiv_next = clkdiv_reg;
    divsel_next = divsel_reg;
    stop_next = stop_reg;
    pause_next = pause_reg;
    cap_lo_next = cap_lo_reg;
    rdata_next = rdata_reg;
    pad_next = lvl & run_en;
    if (reg_wr)
    begin
      case (reg_addr)
        wg_pkg::WG_A_SUB5_P7: sub5_p7_next = reg_wdata;
        wg_pkg::WG_A_SUB5_P6: sub5_p6_next = reg_wdata;
        wg_pkg::WG_A_CNT_P7: cnt_p7_next = reg_wdata;
        wg_pkg::WG_A_CNT_P6: cnt_p6_next = reg_wdata;
        wg_pkg::WG_A_CFG: cfg_next = reg_wdata;
        wg_pkg::WG_A_CHAIN: chain_next = reg_wdata[6:0];
        wg_pkg::WG_A_CLKDIV: clkdiv_next = reg_wdata;
        wg_pkg::WG_A_DIVSEL: divsel_next = reg_wdata;
        wg_pkg::WG_A_STOP: stop_next = reg_wdata;
        wg_pkg::WG_A_PAUSE: pause_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        wg_pkg::WG_A_SUB5_P7: rdata_next = sub5_p7_reg;
        wg_pkg::WG_A_SUB5_P6: rdata_next = sub5_p6_reg;
        wg_pkg::WG_A_CNT_P7:
        begin
          rdata_next = rem_byte[7];
          // Latch so a later low read matches this high byte
          if (wide[3])
            cap_lo_next = chan_rem[6][7:0];
        end
        wg_pkg::WG_A_CNT_P6: rdata_next = wide[3] ? cap_lo_reg : rem_byte[6];
        wg_pkg::WG_A_CFG: rdata_next = cfg_reg;
        wg_pkg::WG_A_CHAIN: rdata_next = {1'b0, chain_reg};
        wg_pkg::WG_A_CLKDIV: rdata_next = clkdiv_reg;
        wg_pkg::WG_A_DIVSEL: rdata_next = divsel_reg;
        wg_pkg::WG_A_STOP: rdata_next = stop_reg;
        wg_pkg::WG_A_PAUSE: rdata_next = pause_reg;
        default: rdata_next = wg_pkg::WG_RST8;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sub5_p7_reg <= wg_pkg::WG_RST8;
      sub5_p6_reg <= wg_pkg::WG_RST8;
      cnt_p7_reg <= wg_pkg::WG_RST8;
      cnt_p6_reg <= wg_pkg::WG_RST8;
      cfg_reg <= wg_pkg::WG_RST8;
      chain_reg <= wg_pkg::WG_RST7;
      clkdiv_reg <= wg_pkg::WG_RST8;
      divsel_reg <= wg_pkg::WG_RST8;
      stop_reg <= wg_pkg::WG_RST8;
      pause_reg <= wg_pkg::WG_RST8;
      cap_lo_reg <= wg_pkg::WG_RST8;
      rdata_reg <= wg_pkg::WG_RST8;
      pad_reg <= wg_pkg::WG_RST8;
    end
    else
    begin
      sub5_p7_reg <= sub5_p7_next;
      sub5_p6_reg <= sub5_p6_next;
      cnt_p7_reg <= cnt_p7_next;
      cnt_p6_reg <= cnt_p6_next;
      cfg_reg <= cfg_next;
      chain_reg <= chain_next;
      clkdiv_reg <= clkdiv_next;
      divsel_reg <= divsel_next;
      stop_reg <= stop_next;
      pause_reg <= pause_next;
      cap_lo_reg <= cap_lo_next;
      rdata_reg <= rdata_next;
      pad_reg <= pad_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pad_out = pad_reg;
  assign pad_oe = run_en;

  for (genvar d = 0; d < 2; d++)
  begin : g_div
    wg_clkdiv u_div (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .div(clkdiv_reg[d*wg_pkg::WG_DW +: wg_pkg::WG_DW]),
      .tick(tick[d])
    );
  end

  for (genvar c = 0; c < NP; c++)
  begin : g_chan
    logic wide_c, chained_c, trig_c, wr_c;
    wire [NS*WW-1:0] len_c;
    wire [WW-1:0] prog_c;
    wire [WW-1:0] wdat_c;
    if (c % 2 == 0)
    begin : g_even
      assign wide_c = wide[c/2];
      for (genvar k = 0; k < NS; k++)
      begin : g_len
        assign len_c[k*WW +: WW] = wide_c
          ? {sub_all[((c+1)*NS+k)*BW +: BW], sub_all[(c*NS+k)*BW +: BW]}
          : {8'h00, sub_all[(c*NS+k)*BW +: BW]};
      end
      assign prog_c = wide_c ? prog_all[c*BW +: WW] : {8'h00, prog_all[c*BW +: BW]};
      assign wdat_c = wide_c ? prog_nx[c*BW +: WW] : {8'h00, prog_nx[c*BW +: BW]};
      assign wr_c = wr_all[c] || (wide_c && wr_all[c+1]);
      assign rem_byte[c] = chan_rem[c][7:0];
    end
    else
    begin : g_odd
      assign wide_c = 1'b0;
      for (genvar k = 0; k < NS; k++)
      begin : g_len
        assign len_c[k*WW +: WW] = {8'h00, sub_all[(c*NS+k)*BW +: BW]};
      end
      assign prog_c = {8'h00, prog_all[c*BW +: BW]};
      assign wdat_c = {8'h00, prog_nx[c*BW +: BW]};
      assign wr_c = wr_all[c];
      assign rem_byte[c] = wide[c/2] ? chan_rem[c-1][15:8] : chan_rem[c][7:0];
    end
    assign run_en[c] = cfg_reg[c/2] && !(c % 2 == 1 && wide[c/2]);
    if (c == NP - 1)
    begin : g_tail
      assign chained_c = 1'b0;
      assign trig_c = 1'b0;
    end
    else if (c % 2 == 0 && c < NP - 2)
    begin : g_link_even
      assign chained_c = chain_reg[c];
      assign trig_c = wide_c ? done[c+2] : done[c+1];
    end
    else
    begin : g_link_odd
      assign chained_c = chain_reg[c] && !wide[c/2];
      assign trig_c = done[c+1];
    end
    wg_chan u_chan (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .tick(divsel_reg[c] ? tick[1] : tick[0]),
      .run_en(run_en[c]),
      .pause(pause_reg[c]),
      .stop(stop_reg[c]),
      .chained(chained_c),
      .trig(trig_c),
      .cnt_wr(wr_c),
      .sub_len(len_c),
      .prog_cnt(prog_c),
      .cnt_wdata(wdat_c),
      .pad_level(lvl[c]),
      .done(done[c]),
      .rem(chan_rem[c])
    );
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_sub5_wide;
    wide[3] |-> g_chan[6].len_c[79:64] == {sub5_p7_reg, sub5_p6_reg};
  endproperty
  a_sub5_wide: assert property (p_sub5_wide) else $error("wide sub5 length wrong");
  property p_sub5_narrow;
    !wide[3] |-> g_chan[6].len_c[79:64] == {8'h00, sub5_p6_reg}
      && g_chan[7].len_c[79:64] == {8'h00, sub5_p7_reg};
  endproperty
  a_sub5_narrow: assert property (p_sub5_narrow) else $error("narrow sub5 wrong");
  sequence s_hi_read;
    reg_rd && reg_addr == wg_pkg::WG_A_CNT_P7 && wide[3];
  endsequence
  property p_rem_hi;
    s_hi_read |=> reg_rdata == $past(chan_rem[6][15:8]);
  endproperty
  a_rem_hi: assert property (p_rem_hi) else $error("upper remaining byte wrong");
  property p_lo_latch;
    s_hi_read ##1 (reg_rd && reg_addr == wg_pkg::WG_A_CNT_P6 && wide[3])
      |=> reg_rdata == $past(chan_rem[6][7:0], 2);
  endproperty
  a_lo_latch: assert property (p_lo_latch) else $error("lower byte not latched");
  property p_pair_off;
    !cfg_reg[3] |-> (pad_oe[7:6] == 2'b00) ##1 (pad_out[7:6] == 2'b00);
  endproperty
  a_pair_off: assert property (p_pair_off) else $error("disabled pair driven");
  property p_narrow_drive;
    cfg_reg[3] && !wide[3] |-> pad_oe[7:6] == 2'b11;
  endproperty
  a_narrow_drive: assert property (p_narrow_drive) else $error("narrow pair not driven");
  property p_wide_drop;
    wide[3] |-> !pad_oe[7] ##1 !pad_out[7];
  endproperty
  a_wide_drop: assert property (p_wide_drop) else $error("odd pad driven in wide");
  property p_chain_wide;
    chain_reg[4] && wide[2] |-> g_chan[4].chained_c && g_chan[4].trig_c == done[6];
  endproperty
  a_chain_wide: assert property (p_chain_wide) else $error("wide chain source wrong");
  property p_odd_ignored;
    wide[2] |-> !g_chan[5].chained_c;
  endproperty
  a_odd_ignored: assert property (p_odd_ignored) else $error("odd link used in wide");
  property p_chain6;
    chain_reg[6] && !wide[3] |-> g_chan[6].chained_c && g_chan[6].trig_c == done[7];
  endproperty
  a_chain6: assert property (p_chain6) else $error("pad6 chain wrong");
endmodule
`default_nettype wire
